// ===== logic/fwt_top.sv
// first-wave time-of-flight measurement controller with serial register port
`timescale 1ns/100ps
`default_nettype none
`include "fwt_cfg.svh"

// Function
// - first-wave mode only in long-range setup with the analogue receive path.
// - config 3 bit 30 enters first-wave mode and reinterprets config 3 and 4.
// - bias code in 1 mV steps; 0..15 positive, 16..31 give -1..-16 mV.
// - config 4 bit 13 adds a further +20 mV to the first-wave bias.
// - config 4 bit 14 adds a further -20 mV to the first-wave bias.
// - stops ignored until blocking delay; then only above-bias signal is first wave.
// - after the first-wave width, or at the first-wave edge when width measurement is disabled, the bias returns to 0 mV.
// - three relative wave counts in config 3 pick the captured waves.
// - half-wave period of the first selected wave is measured as reference.
// - width ratio stored as unsigned Q1.7 at result address 8.
// - config 4 bit 16 low enables width measurement, high disables it.
// - config 4 bit 15 picks rising (0) or falling (1) first-wave edge.
// - three results and their average are stored before the interrupt.
// - config 3 bit 31 stores the sum of all results in result 4.
// - with no stop the bias stays at first-wave level, also after overflow ends the measurement.
// - interrupt on enabled alu, count or overflow; first sck rise with ssn_n low clears it.
// - config 3 bits 27-28 select overflow timeout 64..4096 us.
module fwt_top
    import fwt_pkg::*;
#(
    parameter int TIMO_BASE_CYC = `FWT_TIMO_BASE_US * `FWT_CLK_MHZ
) (
    input  wire logic       clk,      // 200 MHz system clock
    input  wire logic       rst_n,    // async reset, active low
    input  wire logic       sck,      // serial clock
    input  wire logic       ssn_n,    // serial select, active low
    input  wire logic       mosi,     // serial data in
    output logic            miso,     // serial data out
    output logic            irq_n,    // interrupt, active low
    input  wire logic       start_in, // start pulse from fire logic
    input  wire logic       stop_in,  // comparator output
    output logic signed [7:0] bias_mv // comparator offset in mV
);
    fwt_state_t       state_ff, nxt_state;
    logic [31:0]      cfg0_ff, cfg2_ff, cfg3_ff, cfg4_ff;
    logic             sck_prev_ff, stop_prev_ff, start_prev_ff;
    logic [5:0]       bit_cnt_ff;
    logic [7:0]       op_ff;
    logic [31:0]      sh_ff;
    logic [1:0]       load_pend_ff;
    logic             miso_ff, irq_n_ff, done_evt_ff, ovf_ff, bias_active_ff;
    logic signed [7:0] bias_mv_ff;
    fwt_time_t        tof_ff, fw_width_ff, ref_width_ff;
    fwt_time_t        res_ff [3];
    logic [25:0]      sum_ff;
    logic [5:0]       wave_cnt_ff;
    logic [1:0]       hit_ff;
    logic             ref_run_ff;
    logic [2:0]       calc_idx_ff;
    logic             wr_en_ff;
    logic [3:0]       wr_addr_ff;
    logic [31:0]      wr_data_ff;

    fwt_mem_if #(.DW(32), .AW(4)) mif ();

    fwt_result_mem #(.DW(32), .AW(4)) u_mem (
        .clk (clk),
        .mif (mif)
    );

    // relative wave count for the given hit index
    function automatic logic [5:0] wave_sel(input logic [31:0] c3, input logic [1:0] idx);
        logic [5:0] s;
        s = c3[`FWT_WSEL_A_LSB +: `FWT_WSEL_W];
        if (idx == 2'h1) s = c3[`FWT_WSEL_B_LSB +: `FWT_WSEL_W];
        if (idx == 2'h2) s = c3[`FWT_WSEL_C_LSB +: `FWT_WSEL_W];
        return s;
    endfunction

    // first-wave bias: upper codes follow the printed table, not pure two's complement
    function automatic logic signed [7:0] bias_of(input logic [31:0] c4);
        logic [4:0]        code;
        logic signed [7:0] v;
        code = c4[`FWT_BIAS_LSB +: `FWT_BIAS_W];
        v = code[4] ? `FWT_POS_MAX_MV - $signed({3'h0, code})
                    : $signed({3'h0, code});
        if (c4[`FWT_PLUS20_BIT]) v = v + `FWT_RANGE_MV;
        if (c4[`FWT_MINUS20_BIT]) v = v - `FWT_RANGE_MV;
        return v;
    endfunction

    // width ratio in Q1.7, saturated at 1.99
    function automatic logic [7:0] ratio_q17(input fwt_time_t num, input fwt_time_t den);
        logic [31:0] q;
        q = 32'h0;
        if (den != 24'h0) q = {1'b0, num, 7'h00} / {8'h00, den};
        return (q > 32'h0000_00ff) ? 8'hff : q[7:0];
    endfunction

    // decoded controls
    logic       fw_mode, pw_on, edge_fall, sck_rise, sck_fall;
    logic       stop_edge, stop_back, start_rise, measuring, timed_out;
    logic       past_block, capture, op_done, read_cmd, init_cmd, write_done, irq_set;
    logic [7:0] nxt_op;
    logic [5:0] nxt_wave;
    fwt_time_t  delay_cyc, timo_cyc;
    logic [31:0] status_word, rd_word;

    assign fw_mode   = cfg3_ff[`FWT_FW_EN_BIT] & cfg0_ff[`FWT_RANGE2_BIT]
                     & cfg0_ff[`FWT_ANALOG_BIT];
    assign pw_on     = ~cfg4_ff[`FWT_PW_DIS_BIT];
    assign edge_fall = cfg4_ff[`FWT_EDGE_BIT];
    assign sck_rise  = sck & ~sck_prev_ff;
    assign sck_fall  = ~sck & sck_prev_ff;
    // active edge for the wave, opposite edge closes a half period
    assign stop_edge = edge_fall ? (stop_prev_ff & ~stop_in)
                                 : (~stop_prev_ff & stop_in);
    assign stop_back = edge_fall ? (~stop_prev_ff & stop_in)
                                 : (stop_prev_ff & ~stop_in);
    assign start_rise = start_in & ~start_prev_ff;
    assign measuring  = state_ff inside {FWT_BLOCK, FWT_SEEK, FWT_WIDTH, FWT_WAVES};
    assign delay_cyc  = {10'h000, cfg2_ff[`FWT_DELAY_INT_LSB +: `FWT_DELAY_INT_W]};
    assign timo_cyc   = 24'(TIMO_BASE_CYC << (`FWT_TIMO_STEP_LOG2
                      * cfg3_ff[`FWT_TIMO_LSB +: 2]));
    assign timed_out  = (tof_ff >= timo_cyc);
    assign past_block = (tof_ff >= delay_cyc);
    assign nxt_wave   = wave_cnt_ff + 6'h01;
    // counts are taken as increasing, so one compare per hit suffices
    assign capture    = fw_mode ? (nxt_wave == wave_sel(cfg3_ff, hit_ff)) : 1'b1;

    // serial decode
    assign nxt_op     = {op_ff[6:0], mosi};
    assign op_done    = sck_rise & ~ssn_n & (bit_cnt_ff == `FWT_OPCODE_BITS);
    assign read_cmd   = op_done & (nxt_op[7:4] == `FWT_OP_READ);
    assign init_cmd   = op_done & (nxt_op == `FWT_OP_INIT);
    assign write_done = sck_rise & ~ssn_n & (bit_cnt_ff == `FWT_FRAME_BITS)
                      & (op_ff[7:3] == `FWT_OP_WRITE);
    assign status_word = {27'h0, state_ff == FWT_DONE, hit_ff, bias_active_ff, ovf_ff};
    assign rd_word    = (op_ff[3:0] == `FWT_STATUS_ADDR) ? status_word : mif.rd_data;

    // input edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_ff   <= 1'b0;
            stop_prev_ff  <= 1'b0;
            start_prev_ff <= 1'b0;
        end else begin
            sck_prev_ff   <= sck;
            stop_prev_ff  <= stop_in;
            start_prev_ff <= start_in;
        end
    end

    // serial shifter; sck is assumed far slower than clk so a load never meets an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff   <= 6'h00;
            op_ff        <= 8'h00;
            sh_ff        <= 32'h0000_0000;
            load_pend_ff <= 2'h0;
        end else begin
            load_pend_ff <= {load_pend_ff[0], read_cmd};
            if (ssn_n) begin
                bit_cnt_ff <= 6'h00;
            end else if (sck_rise) begin
                if (bit_cnt_ff != 6'h3f) bit_cnt_ff <= bit_cnt_ff + 6'h01;
                if (bit_cnt_ff <= `FWT_OPCODE_BITS) op_ff <= nxt_op;
                else sh_ff <= {sh_ff[30:0], mosi};
            end else if (load_pend_ff[1]) begin
                sh_ff <= rd_word;
            end
        end
    end

    // data out changes on the falling sck edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_ff <= 1'b0;
        end else if (ssn_n) begin
            miso_ff <= 1'b0;
        end else if (sck_fall) begin
            miso_ff <= sh_ff[31];
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg0_ff <= `FWT_CFG_RST;
            cfg2_ff <= `FWT_CFG_RST;
            cfg3_ff <= `FWT_CFG_RST;
            cfg4_ff <= `FWT_CFG_RST;
        end else if (write_done) begin
            unique case (op_ff[2:0])
                `FWT_CFG0_ADDR: cfg0_ff <= {sh_ff[30:0], mosi};
                `FWT_CFG2_ADDR: cfg2_ff <= {sh_ff[30:0], mosi};
                `FWT_CFG3_ADDR: cfg3_ff <= {sh_ff[30:0], mosi};
                `FWT_CFG4_ADDR: cfg4_ff <= {sh_ff[30:0], mosi};
                default: ;
            endcase
        end
    end

    // measurement sequence
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FWT_IDLE:  ;
            FWT_ARMED: if (start_rise) nxt_state = FWT_BLOCK;
            FWT_BLOCK: if (past_block) begin
                nxt_state = fw_mode ? FWT_SEEK : FWT_WAVES;
            end
            FWT_SEEK:  if (stop_edge) nxt_state = pw_on ? FWT_WIDTH : FWT_WAVES;
            FWT_WIDTH: if (stop_back) nxt_state = FWT_WAVES;
            FWT_WAVES: if (stop_edge && capture && hit_ff == 2'h2) nxt_state = FWT_CALC;
            FWT_CALC:  if (calc_idx_ff == 3'h4) nxt_state = FWT_DONE;
            FWT_DONE:  ;
        endcase
        if (measuring && timed_out) nxt_state = FWT_DONE;
        if (init_cmd) nxt_state = FWT_ARMED;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= FWT_IDLE;
            done_evt_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            done_evt_ff <= (nxt_state == FWT_DONE) && (state_ff != FWT_DONE);
        end
    end

    // time base, wave counting and captures
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tof_ff         <= 24'h0;
            fw_width_ff    <= 24'h0;
            ref_width_ff   <= 24'h0;
            res_ff         <= '{default: 24'h0};
            sum_ff         <= 26'h0;
            wave_cnt_ff    <= 6'h00;
            hit_ff         <= 2'h0;
            ref_run_ff     <= 1'b0;
            ovf_ff         <= 1'b0;
            bias_active_ff <= 1'b0;
        end else if (init_cmd) begin
            tof_ff         <= 24'h0;
            fw_width_ff    <= 24'h0;
            ref_width_ff   <= 24'h0;
            sum_ff         <= 26'h0;
            wave_cnt_ff    <= 6'h00;
            hit_ff         <= 2'h0;
            ref_run_ff     <= 1'b0;
            ovf_ff         <= 1'b0;
            bias_active_ff <= 1'b1;
        end else begin
            if (measuring) tof_ff <= tof_ff + 24'h1;
            if (measuring && timed_out) ovf_ff <= 1'b1;
            // stops before the window end never reach this state
            if (state_ff == FWT_SEEK && stop_edge) begin
                wave_cnt_ff <= 6'h01;
                if (!pw_on) bias_active_ff <= 1'b0;
            end
            if (state_ff == FWT_WIDTH) begin
                fw_width_ff <= fw_width_ff + 24'h1;
                if (stop_back) bias_active_ff <= 1'b0;
            end
            if (state_ff == FWT_WAVES && stop_edge) begin
                wave_cnt_ff <= nxt_wave;
                if (capture) begin
                    res_ff[hit_ff] <= tof_ff;
                    sum_ff <= sum_ff + {2'h0, tof_ff};
                    hit_ff <= hit_ff + 2'h1;
                    if (hit_ff == 2'h0 && fw_mode && pw_on) ref_run_ff <= 1'b1;
                end
            end
            if (ref_run_ff) begin
                ref_width_ff <= ref_width_ff + 24'h1;
                if (stop_back) ref_run_ff <= 1'b0;
            end
        end
    end

    // result write-back, one word a cycle, all done before the interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calc_idx_ff <= 3'h0;
            wr_en_ff    <= 1'b0;
            wr_addr_ff  <= 4'h0;
            wr_data_ff  <= 32'h0;
        end else if (state_ff == FWT_CALC) begin
            calc_idx_ff <= calc_idx_ff + 3'h1;
            wr_en_ff    <= 1'b1;
            unique case (calc_idx_ff)
                3'h3: begin
                    wr_addr_ff <= `FWT_RES_AVG_ADDR;
                    wr_data_ff <= cfg3_ff[`FWT_AUTO_SUM_BIT] ? {6'h00, sum_ff}
                                : {6'h00, sum_ff / 26'h3};
                end
                3'h4: begin
                    wr_addr_ff <= `FWT_RES_RATIO_ADDR;
                    wr_data_ff <= pw_on ? {24'h0, ratio_q17(fw_width_ff, ref_width_ff)}
                                : 32'h0;
                end
                default: begin
                    wr_addr_ff <= {2'h0, calc_idx_ff[1:0]};
                    wr_data_ff <= {8'h00, res_ff[calc_idx_ff[1:0]]};
                end
            endcase
        end else begin
            calc_idx_ff <= 3'h0;
            wr_en_ff    <= 1'b0;
        end
    end

    assign mif.wr_en   = wr_en_ff;
    assign mif.wr_addr = wr_addr_ff;
    assign mif.wr_data = wr_data_ff;
    assign mif.rd_addr = op_ff[3:0];

    // interrupt: a set in the same cycle as an sck rise wins over the clear
    assign irq_set = done_evt_ff & ((ovf_ff & cfg2_ff[`FWT_INT_OVF_BIT])
                   | (~ovf_ff & (cfg2_ff[`FWT_INT_ALU_BIT] | cfg2_ff[`FWT_INT_CNT_BIT])));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_ff <= 1'b1;
        end else if (irq_set) begin
            irq_n_ff <= 1'b0;
        end else if (sck_rise && !ssn_n) begin
            irq_n_ff <= 1'b1;
        end
    end

    // comparator bias, zero outside first-wave mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bias_mv_ff <= 8'sh00;
        end else begin
            bias_mv_ff <= (fw_mode && bias_active_ff) ? bias_of(cfg4_ff) : 8'sh00;
        end
    end

    assign miso    = miso_ff;
    assign irq_n   = irq_n_ff;
    assign bias_mv = bias_mv_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_width_end;
        state_ff == FWT_WIDTH && stop_back && !timed_out && !init_cmd;
    endsequence
    sequence seq_bias_cleared;
        state_ff == FWT_WAVES ##1 bias_mv_ff == 8'sh00;
    endsequence

    chk_bias_drop_zero: assert property (seq_width_end |=> seq_bias_cleared)
        else $error("bias not cleared after first-wave width");
    chk_block_ignore_stop: assert property (
        state_ff == FWT_BLOCK && !past_block && !init_cmd |=> state_ff inside {FWT_BLOCK, FWT_DONE}
    ) else $error("left blocking window early");
    chk_seek_bias_level: assert property (
        state_ff == FWT_SEEK && $past(state_ff) == FWT_SEEK && $stable(cfg4_ff)
            && $stable(cfg3_ff) && $stable(cfg0_ff) && fw_mode |-> bias_mv_ff == bias_of(cfg4_ff)
    ) else $error("seek bias differs from programmed level");
    chk_ovf_keep_bias: assert property (
        state_ff == FWT_SEEK && timed_out && !init_cmd |=> ovf_ff && state_ff == FWT_DONE
            ##1 bias_mv_ff == $past(bias_mv_ff, 2)
    ) else $error("overflow did not hold the bias");
    chk_pw_skip_width: assert property (
        state_ff == FWT_SEEK && stop_edge && !pw_on && !timed_out && !init_cmd
            |=> state_ff == FWT_WAVES
    ) else $error("width phase not skipped");
    chk_plain_mode_path: assert property (
        state_ff == FWT_BLOCK && !fw_mode && past_block && !timed_out && !init_cmd
            |=> state_ff == FWT_WAVES
    ) else $error("plain mode entered first-wave search");
    chk_irq_sck_clear: assert property (
        !irq_n_ff && sck_rise && !ssn_n && !irq_set |=> irq_n_ff
    ) else $error("sck rise did not clear interrupt");
    chk_results_before_irq: assert property (
        $fell(irq_n_ff) && !ovf_ff |-> $past(wr_en_ff, 2) && $past(wr_addr_ff, 1) == `FWT_RES_RATIO_ADDR
    ) else $error("interrupt before results stored");
endmodule
`default_nettype wire

// ===== shared/fwt_cfg.svh
// register layout, opcodes and timing constants of the first-wave tof controller
`ifndef FWT_CFG_SVH
`define FWT_CFG_SVH

// clock rate and timing
`define FWT_CLK_MHZ        200
`define FWT_TIMO_BASE_US   64
`define FWT_TIMO_STEP_LOG2 2

// serial opcodes
`define FWT_OP_WRITE       5'h10
`define FWT_OP_READ        4'hb
`define FWT_OP_INIT        8'h70
`define FWT_OPCODE_BITS    6'h07
`define FWT_FRAME_BITS     6'h27

// configuration register addresses
`define FWT_CFG0_ADDR      3'h0
`define FWT_CFG2_ADDR      3'h2
`define FWT_CFG3_ADDR      3'h3
`define FWT_CFG4_ADDR      3'h4
`define FWT_CFG_RST        32'h0000_0000

// result addresses
`define FWT_RES_AVG_ADDR   4'h4
`define FWT_RES_RATIO_ADDR 4'h8
`define FWT_STATUS_ADDR    4'hc

// config 0: measurement setup
`define FWT_RANGE2_BIT     11
`define FWT_ANALOG_BIT     12
// config 2: interrupt enables and stop blocking delay
`define FWT_INT_ALU_BIT    29
`define FWT_INT_CNT_BIT    30
`define FWT_INT_OVF_BIT    31
`define FWT_DELAY_INT_LSB  13
`define FWT_DELAY_INT_W    14
// config 3: first-wave fields
`define FWT_WSEL_A_LSB     8
`define FWT_WSEL_B_LSB     14
`define FWT_WSEL_C_LSB     20
`define FWT_WSEL_W         6
`define FWT_TIMO_LSB       27
`define FWT_FW_EN_BIT      30
`define FWT_AUTO_SUM_BIT   31
// config 4: first-wave fields
`define FWT_BIAS_LSB       8
`define FWT_BIAS_W         5
`define FWT_PLUS20_BIT     13
`define FWT_MINUS20_BIT    14
`define FWT_EDGE_BIT       15
`define FWT_PW_DIS_BIT     16
`define FWT_RANGE_MV       8'sh14
`define FWT_POS_MAX_MV     8'sh0f
`define FWT_RATIO_FRAC     7

`endif

// ===== shared/fwt_pkg.sv
// types of the first-wave tof controller
package fwt_pkg;
    typedef enum logic [2:0] {
        FWT_IDLE, FWT_ARMED, FWT_BLOCK, FWT_SEEK, FWT_WIDTH, FWT_WAVES, FWT_CALC, FWT_DONE
    } fwt_state_t;
    typedef logic [23:0] fwt_time_t;
endpackage

// ===== shared/fwt_mem_if.sv
// carrier between the controller and its result memory
`timescale 1ns/100ps
`default_nettype none
interface fwt_mem_if #(parameter int DW = 32, parameter int AW = 4);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== logic/fwt_result_mem.sv
// result memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module fwt_result_mem
    import fwt_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 4
) (
    input  wire logic clk,    // system clock
    fwt_mem_if.mem    mif     // write and read port
);
    logic [DW-1:0] mem_ff [2**AW];

    // no reset on the array: results are undefined until the first measurement
    always_ff @(posedge clk) begin
        if (mif.wr_en) begin
            mem_ff[mif.wr_addr] <= mif.wr_data;
        end
    end

    // read data registered, one cycle after the address
    always_ff @(posedge clk) begin
        mif.rd_data <= mem_ff[mif.rd_addr];
    end
endmodule
`default_nettype wire

// ===== verif/fwt_host_model.sv
// behavioural serial host that configures the controller and reads its results
`timescale 1ns/100ps
`default_nettype none
module fwt_host_model (
    input  wire logic clk,   // system clock, paces the serial phases
    output var logic  sck,   // serial clock, still outside frames
    output var logic  ssn_n, // serial select, active low
    output var logic  mosi,  // serial data to the device
    input  wire logic miso   // serial data from the device
);
    initial begin
        sck = 1'b0;
        ssn_n = 1'b1;
        mosi = 1'b0;
    end
    // four clk per phase so the device's edge finder never misses one
    task automatic phase();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // n bits msb first; r keeps the last 32 bits seen on miso before each rise
    task automatic frame(input logic [39:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        ssn_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = w[39-i];
            phase();
            r = {r[30:0], miso}; // results read straight, no select command
            sck = 1'b1;
            phase();
            sck = 1'b0;
        end
        phase();
        mosi = ~mosi; // a released line must not show its last value
        ssn_n = 1'b1;
        phase();
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench of the first-wave tof controller
`timescale 1ns/100ps
`default_nettype none
`include "fwt_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    logic              clk, rst_n, start_in, stop_in;
    wire logic         sck, ssn_n, mosi, miso, irq_n;
    wire logic signed [7:0] bias_mv;
    int                fails, checked, h, w1, sa, sb, sc, tsel, bv;
    logic signed [7:0] eb;

    fwt_host_model u_host (.clk(clk), .sck(sck), .ssn_n(ssn_n), .mosi(mosi), .miso(miso));
    fwt_top #(.TIMO_BASE_CYC(16)) u_dut (.clk(clk), .rst_n(rst_n), .sck(sck),
        .ssn_n(ssn_n), .mosi(mosi), .miso(miso), .irq_n(irq_n), .start_in(start_in),
        .stop_in(stop_in), .bias_mv(bias_mv));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run();
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.frame({`FWT_OP_WRITE, a, d}, 40, r);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        u_host.frame({`FWT_OP_READ, a, 32'h0}, 40, r);
    endtask
    // m: 3 plain mode, 0 average rising, 1 sum falling no width, 2 empty tube
    // times are taken one clk after the start edge, so a stop at loop step t reads t - 1
    task automatic run(input int m);
        int t, per, sum, er;
        logic [31:0] r;
        h = 6 + $urandom % 7;
        w1 = 3 + $urandom % (h - 2);
        sa = 3 + $urandom % 6; // first count at least 3, increasing
        sb = sa + 1 + $urandom % 3;
        sc = sb + 1 + $urandom % 3;
        tsel = (m == 2) ? $urandom % 3 : 3;
        bv = $urandom % 32;
        t = $urandom % 4;
        per = 2 * h;
        eb = (m == 3) ? 8'sh0 : 8'((bv < 16 ? bv : 15 - bv) + 20 * t[0] - 20 * t[1]);
        stop_in = (m == 1);
        wr(`FWT_CFG0_ADDR, (m == 3) ? 32'h0800 : 32'h1800);
        wr(`FWT_CFG2_ADDR, 32'he000_0000 | (40 << 13));
        wr(`FWT_CFG3_ADDR, 32'((m == 1) << 31 | 1 << 30 | tsel << 27 | sc << 20 | sb << 14
            | sa << 8));
        wr(`FWT_CFG4_ADDR, 32'((m == 1) << 16 | (m == 1) << 15 | t << 13 | bv << 8));
        u_host.frame({`FWT_OP_INIT, 32'h0}, 8, r);
        `CHK("bias armed", eb, bias_mv)
        // start at t 0, noise inside the blocking window, then the echo train
        for (t = 0; t < (m == 2 ? (16 << (2 * tsel)) - 8 : 60 + sc * per); t++) begin
            start_in = (t < 4);
            er = (t >= 10 && t < 14); // early noise must be ignored
            if (m != 2 && t >= 60) er = ((t - 60) % per) < ((t < 60 + per) ? w1 : h);
            stop_in = er[0] ^ (m == 1); // inverted train for falling edge
            if (t == 59) `CHK("bias seek", eb, bias_mv)
            @(posedge clk);
            #1;
        end
        if (m == 2) begin
            `CHK("irq early", 1'b1, irq_n)
            `CHK("bias empty", eb, bias_mv)
        end else begin
            `CHK("bias after", 8'sh0, bias_mv)
        end
        for (t = 0; t < 60 && irq_n !== 1'b0; t++) begin
            @(posedge clk);
            #1;
        end
        `CHK("irq", 1'b0, irq_n)
        if (m == 2) begin
            rd(`FWT_STATUS_ADDR, r);
            `CHK("overflow", 1'b1, r[0])
        end else begin
            sum = 0;
            for (int k = 0; k < 3; k++) begin
                er = 59 + ((m == 3) ? k : (k == 0) ? sa - 1 : (k == 1) ? sb - 1 : sc - 1) * per;
                sum += er;
                rd(k[3:0], r);
                `CHK("hit time", 32'(er), r)
            end
            rd(`FWT_RES_AVG_ADDR, r);
            `CHK("avg or sum", 32'((m == 1) ? sum : sum / 3), r)
            er = (m == 1 || m == 3) ? 0 : (w1 * 128 / h > 255 ? 255 : w1 * 128 / h);
            rd(`FWT_RES_RATIO_ADDR, r);
            `CHK("width ratio", 8'(er), r[7:0])
        end
        `CHK("irq cleared", 1'b1, irq_n)
    endtask

    initial begin
        fails = 0;
        checked = 0;
        rst_n = 1'b0;
        start_in = 1'b0;
        stop_in = 1'b0;
        void'($urandom(32'hcfa0));
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        `CHK("irq reset", 1'b1, irq_n)
        `CHK("bias reset", 8'sh0, bias_mv)
        for (int m = 0; m < 4; m++) run((m + 3) % 4);
        complete_run();
    end
    // watchdog sized well above four runs of at most about 3500 cycles
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
